// >>> bench/gmcc_top_tb_top.sv
// Purpose: self-checking bench for global master clock configuration
// Assumes: reads settle 1 ns after the falling edge; writes land next edge
// Notes:   every check is a register read or a port sample
`default_nettype none
module gmcc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gmcc_pkg::*;
  // short stand-in for the 5 ms crystal settle, keeps the run brief
  localparam int XTAL_SETTLE = 1000;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  gmcc_req_type req = '0;
  logic [3:0]   gpio_in = 4'h0;
  logic [7:0]   pin_strap = 8'h01;
  logic [7:0]   rdata;
  logic         nvm_select, nvm_access, core_reset, external_switch;
  logic         pin_default;
  gmcc_ctl_type ctl;
  int           failures = 0;
  int           check_count = 0;
  always #5 clk = ~clk;
  gmcc_top u_gmcc_top (.clk(clk), .rst(rst), .req(req), .gpio_in(gpio_in),
    .pin_strap(pin_strap), .rdata(rdata), .nvm_select(nvm_select),
    .nvm_access(nvm_access), .core_reset(core_reset), .ctl(ctl),
    .external_switch(external_switch), .pin_default(pin_default));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    req.we = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic n);
    @(negedge clk);
    req.re = 1'b1;
    req.addr = a;
    #1;
    chk("rdata", e, rdata);
    chk("nvm_access", {7'h0, n}, {7'h0, nvm_access});
    // hold the read across one edge so the core sees it as a request
    @(negedge clk);
    req.re = 1'b0;
  endtask : rd
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    rd(ADDR_MCFG1, 8'h00, 1'b0);
    rd(ADDR_MCFG2, 8'h00, 1'b0);
    chk("src", 8'h00, {6'h0, ctl.src});
    chk("ring_en", 8'h01, {7'h0, ctl.ring_osc_enable});
    chk("pin_default", 8'h01, {7'h0, pin_default});
    repeat (XTAL_SETTLE) @(negedge clk);
    wr(ADDR_MCFG1, 8'h10);
    chk("src", 8'h01, {6'h0, ctl.src});
    wr(ADDR_MCFG1, 8'h38);
    chk("src", 8'h02, {6'h0, ctl.src});
    chk("ring_en", 8'h00, {7'h0, ctl.ring_osc_enable});
    wr(ADDR_MCFG1, 8'h05);
    chk("dbl", 8'h01, {7'h0, ctl.doubler_enable});
    chk("xtal", 8'h01, {7'h0, ctl.crystal_drv_enable});
    wr(ADDR_MCFG1, 8'h02);
    chk("dbl", 8'h00, {7'h0, ctl.doubler_enable});
    chk("single", 8'h01, {7'h0, ctl.single_ended_enable});
    chk("xtal", 8'h00, {7'h0, ctl.crystal_drv_enable});
    wr(ADDR_MCFG1, 8'h7f);
    rd(ADDR_MCFG1, 8'h3f, 1'b0);
    wr(ADDR_MCFG2, 8'hff);
    rd(ADDR_MCFG2, 8'h77, 1'b0);
    chk("ainc", 8'h01, {7'h0, ctl.auto_increment_disable});
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_MCFG2, 8'(k * 34));
      chk("range", 8'(k), {6'h0, ctl.mclk_range});
      chk("rvalid", 8'(k != 3), {7'h0, ctl.range_valid});
      chk("sw_src", 8'(k), {6'h0, ctl.external_switch_source});
      gpio_in = 4'h1 << k;
      #1 chk("ext_sw", 8'h01, {7'h0, external_switch});
      @(negedge clk) gpio_in = ~(4'h1 << k);
      #1 chk("ext_sw", 8'h00, {7'h0, external_switch});
    end
    wr(ADDR_BANK_SEL, 8'h01);
    chk("nvm_sel", 8'h01, {7'h0, nvm_select});
    rd(ADDR_BANK_SEL, 8'h00, 1'b0);
    rd(ADDR_MCFG1, 8'h00, 1'b1);
    wr(ADDR_MCFG1, 8'h10);
    wr(ADDR_BANK_SEL, 8'h00);
    rd(ADDR_MCFG1, 8'h3f, 1'b0);
    pin_strap = 8'h00;
    wr(ADDR_MCFG1, 8'h07);
    wr(ADDR_MCFG1, 8'h87);
    chk("core_rst", 8'h01, {7'h0, core_reset});
    rd(ADDR_MCFG1, 8'h80, 1'b0);
    rd(ADDR_MCFG2, 8'h00, 1'b0);
    wr(ADDR_MCFG1, 8'hbf);
    rd(ADDR_MCFG1, 8'h80, 1'b0);
    chk("pin_default", 8'h01, {7'h0, pin_default});
    wr(ADDR_BANK_SEL, 8'h01);
    chk("nvm_sel", 8'h00, {7'h0, nvm_select});
    wr(ADDR_MCFG1, 8'h00);
    chk("core_rst", 8'h00, {7'h0, core_reset});
    chk("dbl", 8'h00, {7'h0, ctl.doubler_enable});
    chk("src", 8'h00, {6'h0, ctl.src});
    chk("ring_en", 8'h01, {7'h0, ctl.ring_osc_enable});
    wr(ADDR_MCFG1, 8'h10);
    chk("src", 8'h01, {6'h0, ctl.src});
    end_of_test();
  end
endmodule : gmcc_top_tb_top
`default_nettype wire

// >>> shared/gmcc_pkg.sv
// Purpose: constants and types for the global master clock configuration
// Assumes: 8-bit register port, one clock
// Notes:   offsets and field positions of the three global registers
`default_nettype none
package gmcc_pkg;
  localparam logic [7:0] ADDR_BANK_SEL  = 8'h00;
  localparam logic [7:0] ADDR_MCFG1     = 8'h09;
  localparam logic [7:0] ADDR_MCFG2     = 8'h0a;
  localparam logic [7:0] RESET_VAL      = 8'h00;
  localparam int         B_BANK         = 0;
  localparam int         B_SOFT_RST     = 7;
  localparam int         B_FROM_IN1     = 5;
  localparam int         B_SRC_SEL      = 4;
  localparam int         B_ROSC_PD      = 3;
  localparam int         B_DBL          = 2;
  localparam int         B_AINC_DIS     = 4;
  localparam logic [7:0] MCFG1_WMASK    = 8'hbf;
  localparam logic [7:0] MCFG2_WMASK    = 8'h77;
  localparam logic [1:0] XPIN_OFF       = 2'h0;
  localparam logic [1:0] XPIN_CRYSTAL   = 2'h1;
  localparam logic [1:0] XPIN_SINGLE    = 2'h2;
  localparam logic [1:0] MRANGE_LOW     = 2'h0;
  localparam logic [1:0] MRANGE_MID     = 2'h1;
  localparam logic [1:0] MRANGE_HIGH    = 2'h2;
  localparam logic [1:0] MRANGE_NONE    = 2'h3;
  localparam int         B_XPIN         = 0;
  localparam int         W_XPIN         = 2;
  localparam int         B_MRANGE       = 1;
  localparam int         W_MRANGE       = 2;
  localparam int         B_EXT_SW       = 5;
  localparam int         W_EXT_SW       = 2;
  localparam int         B_STRAP_DEF    = 0;
  localparam logic [7:0] MCFG1_RST_ONLY = 8'h80;

  typedef enum logic [1:0] {
    GMCC_SRC_RING = 2'b00,
    GMCC_SRC_XPIN = 2'b01,
    GMCC_SRC_IN1  = 2'b10
  } gmcc_src_type;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gmcc_req_type;

  typedef struct packed {
    gmcc_src_type src;
    logic         ring_osc_enable;
    logic         doubler_enable;
    logic         crystal_drv_enable;
    logic         single_ended_enable;
    logic [1:0]   mclk_range;
    logic         range_valid;
    logic [1:0]   external_switch_source;
    logic         auto_increment_disable;
  } gmcc_ctl_type;
endpackage : gmcc_pkg
`default_nettype wire

// >>> src/gmcc_top.sv
// Purpose: global master clock and bank select configuration logic
// Assumes: register port is synchronous; reads return the same cycle
// Notes:   soft reset holds core reset while the reset bit is set
`default_nettype none
// Contract
// - bank bit maps registers or nonvolatile memory
// - bank select is write-only, reads zero
// - soft reset forces all fields except the reset bit to default
// - soft reset keeps pin-captured defaults
// - input-one select overrides master clock select
// - source bit picks ring or oscillator pin
// - power-down bit stops ring oscillator
// - doubler bit enables or powers doubler
// - crystal pin mode decodes three modes
// - auto-increment disable stops address increment
// - range field decodes three frequency bands
// - switch source field picks one of four pins
module gmcc_top
  import gmcc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire gmcc_pkg::gmcc_req_type req,
  input  wire logic [3:0]             gpio_in,
  input  wire logic [7:0]             pin_strap,
  output logic [7:0]                  rdata,
  output logic                        nvm_select,
  output logic                        nvm_access,
  output logic                        core_reset,
  output gmcc_pkg::gmcc_ctl_type      ctl,
  output logic                        external_switch,
  output logic                        pin_default
);
  logic [7:0] bank_r, bank_nxt;
  logic [7:0] mcfg1_r, mcfg1_nxt;
  logic [7:0] mcfg2_r, mcfg2_nxt;
  logic [7:0] strap_r, strap_nxt;
  logic       strap_take_r, strap_take_nxt;
  logic       soft_rst;
  logic       wr_upper;
  logic [1:0] xpin_mode;
  logic [1:0] range_code;
  logic [1:0] switch_pick;

  assign soft_rst    = mcfg1_r[B_SOFT_RST];
  assign wr_upper    = req.addr != ADDR_BANK_SEL;
  // fields sliced once so the decode and its checks read the same bits
  assign xpin_mode   = mcfg1_r[B_XPIN +: W_XPIN];
  assign range_code  = mcfg2_r[B_MRANGE +: W_MRANGE];
  assign switch_pick = mcfg2_r[B_EXT_SW +: W_EXT_SW];

  always_comb begin
    bank_nxt       = bank_r;
    mcfg1_nxt      = mcfg1_r;
    mcfg2_nxt      = mcfg2_r;
    strap_nxt      = strap_r;
    strap_take_nxt = 1'b0;
    if (strap_take_r) begin
      strap_nxt = pin_strap;
    end
    if (req.we && req.addr == ADDR_BANK_SEL) begin
      bank_nxt         = RESET_VAL;
      bank_nxt[B_BANK] = req.wdata[B_BANK];
    end
    // registers at upper offsets are hidden while the memory bank is mapped
    if (req.we && wr_upper && !bank_r[B_BANK]) begin
      if (req.addr == ADDR_MCFG1) begin
        mcfg1_nxt = req.wdata & MCFG1_WMASK;
      end else if (req.addr == ADDR_MCFG2) begin
        mcfg2_nxt = req.wdata & MCFG2_WMASK;
      end
    end
    if (soft_rst) begin
      // only the reset bit itself may change while held
      bank_nxt  = RESET_VAL;
      mcfg2_nxt = RESET_VAL;
      mcfg1_nxt = mcfg1_nxt & MCFG1_RST_ONLY;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bank_r       <= RESET_VAL;
      mcfg1_r      <= RESET_VAL;
      mcfg2_r      <= RESET_VAL;
      strap_r      <= RESET_VAL;
      strap_take_r <= 1'b1;
    end else begin
      bank_r       <= bank_nxt;
      mcfg1_r      <= mcfg1_nxt;
      mcfg2_r      <= mcfg2_nxt;
      strap_r      <= strap_nxt;
      strap_take_r <= strap_take_nxt;
    end
  end

  // reads of the bank select return zero, not the written value
  always_comb begin
    rdata = RESET_VAL;
    if (req.re && !bank_r[B_BANK]) begin
      if (req.addr == ADDR_MCFG1) begin
        rdata = mcfg1_r;
      end else if (req.addr == ADDR_MCFG2) begin
        rdata = mcfg2_r;
      end
    end
  end

  assign nvm_select  = bank_r[B_BANK];
  assign nvm_access  = (req.we || req.re) && wr_upper && bank_r[B_BANK];
  assign core_reset  = soft_rst;
  assign pin_default = strap_r[B_STRAP_DEF];

  always_comb begin
    ctl = '0;
    if (mcfg1_r[B_FROM_IN1]) begin
      ctl.src = GMCC_SRC_IN1;
    end else if (mcfg1_r[B_SRC_SEL]) begin
      ctl.src = GMCC_SRC_XPIN;
    end else begin
      ctl.src = GMCC_SRC_RING;
    end
    ctl.ring_osc_enable     = !mcfg1_r[B_ROSC_PD];
    ctl.doubler_enable      = mcfg1_r[B_DBL];
    ctl.crystal_drv_enable  = xpin_mode == XPIN_CRYSTAL;
    ctl.single_ended_enable = xpin_mode == XPIN_SINGLE;
    ctl.mclk_range          = range_code;
    ctl.range_valid         = range_code != MRANGE_NONE;
    ctl.external_switch_source = switch_pick;
    ctl.auto_increment_disable = mcfg2_r[B_AINC_DIS];
  end

  assign external_switch = gpio_in[switch_pick];

  a_soft_reset_clears : assert property (
    @(posedge clk) disable iff (rst)
    soft_rst |=> mcfg2_r == RESET_VAL &&
      (mcfg1_r & ~MCFG1_RST_ONLY) == RESET_VAL)
    else $error("fields not default during soft reset");
  a_in1_override : assert property (
    @(posedge clk) disable iff (rst)
    mcfg1_r[B_FROM_IN1] |-> ctl.src == GMCC_SRC_IN1)
    else $error("input one did not override source");
  a_src_select : assert property (
    @(posedge clk) disable iff (rst)
    !mcfg1_r[B_FROM_IN1] |->
      (ctl.src == GMCC_SRC_XPIN) == mcfg1_r[B_SRC_SEL])
    else $error("source select mismatch");
  a_src_ring : assert property (
    @(posedge clk) disable iff (rst)
    !mcfg1_r[B_FROM_IN1] && !mcfg1_r[B_SRC_SEL] |->
      ctl.src == GMCC_SRC_RING)
    else $error("ring oscillator not selected");
  a_bank_write : assert property (
    @(posedge clk) disable iff (rst)
    (req.we && req.addr == ADDR_BANK_SEL && !soft_rst)
      |=> nvm_select == $past(req.wdata[B_BANK]))
    else $error("bank select not taken");
  a_bank_reads_zero : assert property (
    @(posedge clk) disable iff (rst)
    (req.addr == ADDR_BANK_SEL) |-> rdata == RESET_VAL)
    else $error("bank select read nonzero");
  a_ring_pd : assert property (
    @(posedge clk) disable iff (rst)
    ctl.ring_osc_enable != mcfg1_r[B_ROSC_PD])
    else $error("ring oscillator power mismatch");
  a_mode_exclusive : assert property (
    @(posedge clk) disable iff (rst)
    !(ctl.crystal_drv_enable && ctl.single_ended_enable))
    else $error("two crystal pin modes active");
  a_resume_default : assert property (
    @(posedge clk) disable iff (rst)
    $fell(soft_rst) |-> mcfg2_r == RESET_VAL && !ctl.doubler_enable)
    else $error("fields not default after soft reset");
  a_switch_pick : assert property (
    @(posedge clk) disable iff (rst)
    external_switch == gpio_in[ctl.external_switch_source])
    else $error("switch source mismatch");
  a_doubler_follow : assert property (
    @(posedge clk) disable iff (rst)
    ctl.doubler_enable == mcfg1_r[B_DBL])
    else $error("doubler enable mismatch");
  a_xtal_decode : assert property (
    @(posedge clk) disable iff (rst)
    ctl.crystal_drv_enable == (xpin_mode == XPIN_CRYSTAL))
    else $error("crystal driver decode mismatch");
  a_single_decode : assert property (
    @(posedge clk) disable iff (rst)
    ctl.single_ended_enable == (xpin_mode == XPIN_SINGLE))
    else $error("single ended decode mismatch");
  a_range_valid : assert property (
    @(posedge clk) disable iff (rst)
    ctl.range_valid == (ctl.mclk_range != MRANGE_NONE))
    else $error("range valid flag mismatch");
  a_ainc_follow : assert property (
    @(posedge clk) disable iff (rst)
    ctl.auto_increment_disable == mcfg2_r[B_AINC_DIS])
    else $error("auto increment disable mismatch");
  a_upper_refused : assert property (
    @(posedge clk) disable iff (rst)
    req.we && nvm_select && req.addr != ADDR_BANK_SEL
      |=> mcfg1_r == $past(mcfg1_r) && mcfg2_r == $past(mcfg2_r))
    else $error("register written while memory mapped");
  a_nvm_read_blank : assert property (
    @(posedge clk) disable iff (rst)
    req.re && nvm_select && req.addr != ADDR_BANK_SEL
      |-> nvm_access && rdata == RESET_VAL)
    else $error("register read while memory mapped");
  a_strap_hold : assert property (
    @(posedge clk) disable iff (rst)
    soft_rst && !strap_take_r |=> pin_default == $past(pin_default))
    else $error("pin default resampled in soft reset");
  a_bank_in_reset : assert property (
    @(posedge clk) disable iff (rst)
    soft_rst |=> !nvm_select)
    else $error("bank select kept during soft reset");
  a_reset_bit_only : assert property (
    @(posedge clk) disable iff (rst)
    soft_rst && req.we && req.addr == ADDR_MCFG1
      |=> core_reset == $past(req.wdata[B_SOFT_RST]))
    else $error("reset bit not writable in soft reset");
  a_write_lands : assert property (
    @(posedge clk) disable iff (rst)
    req.we && !nvm_select && !soft_rst && req.addr == ADDR_MCFG2
      |=> mcfg2_r == ($past(req.wdata) & MCFG2_WMASK))
    else $error("second register write not taken");

  c_soft_reset : cover property (@(posedge clk) $rose(soft_rst));
  c_soft_exit : cover property (@(posedge clk) $fell(soft_rst));
  c_in1_source : cover property (@(posedge clk) ctl.src == GMCC_SRC_IN1);
  c_xpin_source : cover property (@(posedge clk) ctl.src == GMCC_SRC_XPIN);
  c_nvm_mapped : cover property (@(posedge clk) nvm_access);
endmodule : gmcc_top
`default_nettype wire
